// ---- core/sideband_pkg.sv ----
// Shared constants and types for the switch sideband control block
package sideband_pkg;

  localparam int unsigned CLK_KHZ            = 125000;
  localparam int unsigned NUM_PORTS          = 3;
  localparam int unsigned GPIO_W             = 8;
  localparam int unsigned SMB_ADDR_LSB       = 5;
  localparam int unsigned SMB_ADDR_W         = 3;
  localparam int unsigned TAP_CHAIN_W        = 32;
  localparam int unsigned TAP_IR_W           = 4;

  // Hold of a downstream reset after a slot insertion
  localparam int unsigned INSERT_RESET_US    = 1;
  localparam int unsigned INSERT_RESET_CYC   = INSERT_RESET_US * CLK_KHZ / 1000;
  localparam int unsigned INSERT_CNT_W       = $clog2(INSERT_RESET_CYC + 1);

  // Error indicator blink half period (4 Hz blink)
  localparam int unsigned BLINK_HALF_MS      = 125;
  localparam int unsigned BLINK_HALF_CYC     = BLINK_HALF_MS * CLK_KHZ;
  localparam int unsigned BLINK_CNT_W        = 32;

  localparam logic        POWER_SAVE_RESET   = 1'b0;
  localparam logic        REFCLK_SEL_RESET   = 1'b0;
  localparam logic [TAP_IR_W-1:0]    TAP_IR_RESET    = 4'h1;
  localparam logic [TAP_CHAIN_W-1:0] TAP_CHAIN_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    TAP_RESET = 2'b00,
    TAP_IDLE  = 2'b01,
    TAP_SHIFT = 2'b11
  } tap_state_t;

  // All pins that arrive from outside the core clock domain
  typedef struct packed {
    logic                    fundamental_reset_n;
    logic                    wake_request_n;
    logic [2:1]              slot_present_n;
    logic                    shared_refclk_select;
    logic                    scan_enable;
    logic                    tck;
    logic                    tms;
    logic                    tdi;
    logic                    test_reset_n;
    logic                    power_saving_strap;
    logic [GPIO_W-1:0]       gpio;
  } pins_t;

endpackage : sideband_pkg

// ---- core/blink_if.sv ----
// Blink phase carried from the blink generator to the indicator logic
interface blink_if;
  logic phase;
  logic restart;
  modport gen (output phase, input restart);
  modport use_phase (input phase, output restart);
endinterface : blink_if

// ---- core/blink_gen.sv ----
// Free-running blink phase generator for the error indicators
module blink_gen #(
  parameter int unsigned HALF_CYC = sideband_pkg::BLINK_HALF_CYC
) (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  // Phase output
  blink_if.gen      blink
);

  localparam logic [sideband_pkg::BLINK_CNT_W-1:0] LAST =
    sideband_pkg::BLINK_CNT_W'(HALF_CYC - 1);

  logic [sideband_pkg::BLINK_CNT_W-1:0] count;
  logic                                 phase;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= '0;
      phase <= 1'b0;
    end else if (blink.restart) begin
      count <= '0;
      phase <= 1'b0;
    end else if (count == LAST) begin
      count <= '0;
      phase <= ~phase; // RULE15
    end else begin
      count <= count + 1'b1;
    end
  end

  assign blink.phase = phase;

  property p_blink_bound;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    count <= LAST;
  endproperty
  a_blink_bound: assert property (p_blink_bound) else $error("blink counter past its period"); // RULE15

endmodule : blink_gen

// ---- core/switch_sideband_control.sv ----
// Sideband control: resets, slot sense, wake, error lamps, GPIO, strap, scan and TAP
// Function
// [RULE1] Wake request low makes the upstream port request a beacon.
// [RULE2] Fundamental reset clears all internal state except sticky flags.
// [RULE3] Downstream resets active during fundamental reset or just after slot insertion.
// [RULE4] Presence input low means device present; high means slot empty.
// [RULE5] Shared reference clock select high means platform clock used.
// [RULE6] Scan enable pin driven as output at 0 outside manufacturing test.
// [RULE7] Error indicator toggles while a PHY error is detected on its port.
// [RULE8] Error indicator stays low while no PHY error is detected.
// [RULE9] Each GPIO pin is input-only or bidirectional per output enable setting.
// [RULE10] GPIO 7 to 5 give SMBus slave address bits 2 to 0.
// [RULE11] Power saving strap sampled at reset; high enables power saving.
// [RULE12] Test reset low forces the TAP into its initialised state.
// [RULE13] With scan enable high, data shifts out on TDO timed by TCK.
// [RULE14] With scan enable high, data and instructions shift in from TDI.
// [RULE15] Error indicator blinks at a few hertz from a divided core clock.
module switch_sideband_control #(
  parameter int unsigned BLINK_HALF_CYC = sideband_pkg::BLINK_HALF_CYC
) (
  // Clock and reset
  input  wire logic                                core_clk_i,
  input  wire logic                                rst_n_i,
  // Reset, wake and slot pins
  input  wire logic                                fundamental_reset_n_i,
  input  wire logic                                wake_request_n_i,
  input  wire logic [2:1]                          slot_present_n_i,
  input  wire logic                                shared_refclk_select_i,
  output logic      [2:1]                          downstream_port_reset_n_o,
  output logic                                     beacon_request_o,
  output logic      [2:1]                          slot_occupied_o,
  output logic                                     shared_refclk_used_o,
  // PHY error status
  input  wire logic [sideband_pkg::NUM_PORTS-1:0]  phy_error_i,
  input  wire logic [sideband_pkg::NUM_PORTS-1:0]  phy_error_seen_clear_i,
  output logic      [sideband_pkg::NUM_PORTS-1:0]  phy_error_indicator_o,
  output logic      [sideband_pkg::NUM_PORTS-1:0]  phy_error_seen_o,
  // General purpose pins
  input  wire logic [sideband_pkg::GPIO_W-1:0]     gpio_i,
  input  wire logic [sideband_pkg::GPIO_W-1:0]     gpio_out_value_i,
  input  wire logic [sideband_pkg::GPIO_W-1:0]     gpio_output_enable_i,
  input  wire logic                                smbus_used_i,
  output logic      [sideband_pkg::GPIO_W-1:0]     gpio_o,
  output logic      [sideband_pkg::GPIO_W-1:0]     gpio_oe_o,
  output logic      [sideband_pkg::GPIO_W-1:0]     gpio_in_o,
  output logic      [sideband_pkg::SMB_ADDR_W-1:0] smbus_address_low_o,
  // Power saving strap
  input  wire logic                                power_saving_strap_i,
  output logic                                     power_saving_enable_o,
  // Scan and boundary scan
  input  wire logic                                scan_test_mode_i,
  input  wire logic                                scan_enable_i,
  output logic                                     scan_enable_o,
  output logic                                     scan_enable_oe_o,
  input  wire logic                                tck_i,
  input  wire logic                                tms_i,
  input  wire logic                                tdi_i,
  input  wire logic                                test_reset_n_i,
  output logic                                     tdo_o
);

  sideband_pkg::pins_t pins_raw;
  sideband_pkg::pins_t pins_meta;
  sideband_pkg::pins_t pins;

  assign pins_raw = '{fundamental_reset_n:  fundamental_reset_n_i,
                      wake_request_n:       wake_request_n_i,
                      slot_present_n:       slot_present_n_i,
                      shared_refclk_select: shared_refclk_select_i,
                      scan_enable:          scan_enable_i,
                      tck:                  tck_i,
                      tms:                  tms_i,
                      tdi:                  tdi_i,
                      test_reset_n:         test_reset_n_i,
                      power_saving_strap:   power_saving_strap_i,
                      gpio:                 gpio_i};

  // Two-stage synchroniser; pull-up pins reset high
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pins_meta <= '{fundamental_reset_n: 1'b1, wake_request_n: 1'b1, test_reset_n: 1'b1,
                     slot_present_n: 2'h3, default: '0};
      pins      <= '{fundamental_reset_n: 1'b1, wake_request_n: 1'b1, test_reset_n: 1'b1,
                     slot_present_n: 2'h3, default: '0};
    end else begin
      pins_meta <= pins_raw;
      pins      <= pins_meta;
    end
  end

  logic fund_active;
  assign fund_active = ~pins.fundamental_reset_n;

  // Wake, reference clock and slot presence
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      beacon_request_o     <= 1'b0;
      shared_refclk_used_o <= sideband_pkg::REFCLK_SEL_RESET;
      slot_occupied_o      <= '0;
    end else if (fund_active) begin
      beacon_request_o     <= 1'b0; // RULE2
      shared_refclk_used_o <= sideband_pkg::REFCLK_SEL_RESET;
      slot_occupied_o      <= '0;
    end else begin
      beacon_request_o     <= ~pins.wake_request_n; // RULE1
      shared_refclk_used_o <= pins.shared_refclk_select; // RULE5
      slot_occupied_o      <= ~pins.slot_present_n; // RULE4
    end
  end

  // Downstream resets, per slot
  logic [2:1] present_d;
  for (genvar p = 1; p <= 2; p++) begin : g_slot
    logic [sideband_pkg::INSERT_CNT_W-1:0] hold;
    logic                                  inserted;
    assign inserted = ~pins.slot_present_n[p] & ~present_d[p];

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        present_d[p] <= 1'b0;
        hold         <= '0;
        downstream_port_reset_n_o[p] <= 1'b0;
      end else begin
        present_d[p] <= ~pins.slot_present_n[p]; // RULE4
        if (fund_active) begin
          hold <= '0;
        end else if (inserted) begin
          hold <= sideband_pkg::INSERT_CNT_W'(sideband_pkg::INSERT_RESET_CYC);
        end else if (hold != '0) begin
          hold <= hold - 1'b1;
        end
        downstream_port_reset_n_o[p] <= ~(fund_active | inserted | (hold > 1)); // RULE3
      end
    end
  end

  // PHY error lamps and sticky flags
  blink_if blink ();
  blink_gen #(
    .HALF_CYC (BLINK_HALF_CYC)
  ) u_blink (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .blink      (blink.gen)
  );
  assign blink.restart = fund_active;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phy_error_indicator_o <= '0;
    end else if (fund_active) begin
      phy_error_indicator_o <= '0;
    end else begin
      phy_error_indicator_o <= phy_error_i & {sideband_pkg::NUM_PORTS{blink.phase}}; // RULE7 RULE8
    end
  end

  // Sticky: cleared by the core reset or phy_error_seen_clear_i (a new error wins), never by the fundamental reset
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phy_error_seen_o <= '0;
    end else begin
      phy_error_seen_o <= (phy_error_seen_o & ~phy_error_seen_clear_i) | phy_error_i; // RULE2
    end
  end

  // General purpose pins
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gpio_o    <= '0;
      gpio_oe_o <= '0;
      gpio_in_o <= '0;
      smbus_address_low_o <= '0;
    end else if (fund_active) begin
      gpio_o    <= '0;
      gpio_oe_o <= '0;
      gpio_in_o <= pins.gpio;
      smbus_address_low_o <= '0;
    end else begin
      gpio_o    <= gpio_out_value_i;
      gpio_oe_o <= gpio_output_enable_i; // RULE9
      gpio_in_o <= pins.gpio;
      smbus_address_low_o <= smbus_used_i ?
        pins.gpio[sideband_pkg::SMB_ADDR_LSB +: sideband_pkg::SMB_ADDR_W] : '0; // RULE10
    end
  end

  // Strap follows the pin while the fundamental reset is held, frozen on release
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_saving_enable_o <= sideband_pkg::POWER_SAVE_RESET;
    end else if (fund_active) begin
      power_saving_enable_o <= pins.power_saving_strap; // RULE11
    end
  end

  // Scan enable pin is an output at 0 outside manufacturing test
  assign scan_enable_o    = 1'b0; // RULE6
  assign scan_enable_oe_o = ~scan_test_mode_i; // RULE6

  // Boundary scan access port
  sideband_pkg::tap_state_t tap_state;
  logic                                    tck_d;
  logic                                    tck_rise;
  logic                                    scan_on;
  logic [sideband_pkg::TAP_CHAIN_W-1:0]    tap_chain;
  logic [sideband_pkg::TAP_IR_W-1:0]       tap_ir;

  assign tck_rise = pins.tck & ~tck_d;
  assign scan_on  = scan_test_mode_i & pins.scan_enable;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tck_d     <= 1'b0;
      tap_state <= sideband_pkg::TAP_RESET;
    end else begin
      tck_d <= pins.tck;
      if (!pins.test_reset_n || fund_active) begin
        tap_state <= sideband_pkg::TAP_RESET; // RULE12
      end else if (tck_rise) begin
        unique case (tap_state)
          sideband_pkg::TAP_RESET: tap_state <= pins.tms ? sideband_pkg::TAP_RESET : sideband_pkg::TAP_IDLE;
          sideband_pkg::TAP_IDLE:  tap_state <= scan_on ? sideband_pkg::TAP_SHIFT : sideband_pkg::TAP_IDLE;
          sideband_pkg::TAP_SHIFT: tap_state <= scan_on ? sideband_pkg::TAP_SHIFT : sideband_pkg::TAP_IDLE;
          default:                 tap_state <= sideband_pkg::TAP_RESET;
        endcase
      end
    end
  end

  // TMS high while shifting selects the instruction path
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tap_chain <= sideband_pkg::TAP_CHAIN_RESET;
      tap_ir    <= sideband_pkg::TAP_IR_RESET;
      tdo_o     <= 1'b0;
    end else if (tap_state == sideband_pkg::TAP_RESET) begin
      tap_chain <= sideband_pkg::TAP_CHAIN_RESET; // RULE12
      tap_ir    <= sideband_pkg::TAP_IR_RESET;
      tdo_o     <= 1'b0;
    end else if (tck_rise && tap_state == sideband_pkg::TAP_SHIFT && scan_on) begin
      if (pins.tms) begin
        tap_ir <= {pins.tdi, tap_ir[sideband_pkg::TAP_IR_W-1:1]}; // RULE14
        tdo_o  <= tap_ir[0]; // RULE13
      end else begin
        tap_chain <= {pins.tdi, tap_chain[sideband_pkg::TAP_CHAIN_W-1:1]}; // RULE14
        tdo_o     <= tap_chain[0]; // RULE13
      end
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_beacon;
    !fund_active && !pins.wake_request_n |=> beacon_request_o;
  endproperty
  a_beacon: assert property (p_beacon) else $error("wake did not raise beacon"); // RULE1

  property p_fund_clears;
    fund_active |=> !beacon_request_o && phy_error_indicator_o == '0 && tap_state == sideband_pkg::TAP_RESET;
  endproperty
  a_fund_clears: assert property (p_fund_clears) else $error("state survived fundamental reset"); // RULE2

  property p_sticky;
    phy_error_seen_o[0] && !phy_error_seen_clear_i[0] |=> phy_error_seen_o[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky error flag lost"); // RULE2

  property p_ds_fund;
    fund_active |=> downstream_port_reset_n_o == 2'h0;
  endproperty
  a_ds_fund: assert property (p_ds_fund) else $error("downstream reset not active"); // RULE3

  property p_ds_insert;
    !fund_active && $fell(pins.slot_present_n[1]) |=> (!downstream_port_reset_n_o[1] || fund_active) [*8];
  endproperty
  a_ds_insert: assert property (p_ds_insert) else $error("no reset after insertion"); // RULE3

  property p_present;
    !fund_active |=> slot_occupied_o == ~$past(pins.slot_present_n);
  endproperty
  a_present: assert property (p_present) else $error("presence polarity wrong"); // RULE4

  property p_refclk;
    !fund_active |=> shared_refclk_used_o == $past(pins.shared_refclk_select);
  endproperty
  a_refclk: assert property (p_refclk) else $error("refclk select not followed"); // RULE5

  property p_scan_out;
    !scan_test_mode_i |-> scan_enable_oe_o && !scan_enable_o;
  endproperty
  a_scan_out: assert property (p_scan_out) else $error("scan enable not driven low"); // RULE6

  property p_blink;
    !fund_active && phy_error_i[0] |=> phy_error_indicator_o[0] == $past(blink.phase);
  endproperty
  a_blink: assert property (p_blink) else $error("indicator not blinking"); // RULE7

  property p_lamp_off;
    phy_error_i == '0 |=> phy_error_indicator_o == '0;
  endproperty
  a_lamp_off: assert property (p_lamp_off) else $error("indicator lit without error"); // RULE8

  property p_gpio_oe;
    !fund_active |=> gpio_oe_o == $past(gpio_output_enable_i);
  endproperty
  a_gpio_oe: assert property (p_gpio_oe) else $error("gpio enable not applied"); // RULE9

  property p_smb;
    !fund_active && smbus_used_i |=> smbus_address_low_o == $past(pins.gpio[7:5]);
  endproperty
  a_smb: assert property (p_smb) else $error("smbus address bits wrong"); // RULE10

  property p_strap_hold;
    !fund_active |=> $stable(power_saving_enable_o);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed outside reset"); // RULE11

  property p_tap_reset;
    !pins.test_reset_n |=> tap_state == sideband_pkg::TAP_RESET;
  endproperty
  a_tap_reset: assert property (p_tap_reset) else $error("tap not reset"); // RULE12

  property p_tdo;
    tck_rise && tap_state == sideband_pkg::TAP_SHIFT && scan_on && !pins.tms && pins.test_reset_n && !fund_active
      |=> tdo_o == $past(tap_chain[0]) && tap_chain[31] == $past(pins.tdi);
  endproperty
  a_tdo: assert property (p_tdo) else $error("scan shift wrong"); // RULE13

endmodule : switch_sideband_control

// ---- dv/host_slot_model.sv ----
// Host platform and slot device model driving the sideband pins
module host_slot_model (
  // Clock
  input  wire logic       core_clk_i,
  // Requests from the bench
  input  wire logic       host_reset_i,
  input  wire logic       wake_i,
  input  wire logic [2:1] insert_i,
  input  wire logic       refclk_sel_i,
  input  wire logic       strap_i,
  input  wire logic [7:0] gpio_ext_i,
  // Device side of the general purpose pins
  input  wire logic [7:0] gpio_drv_i,
  input  wire logic [7:0] gpio_oe_i,
  // Pins
  output logic            fundamental_reset_n_o,
  output logic            wake_request_n_o,
  output logic      [2:1] slot_present_n_o,
  output logic            shared_refclk_select_o,
  output logic            power_saving_strap_o,
  output logic      [7:0] gpio_wire_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] strap_hold = 4'hF;

  always @(posedge core_clk_i) begin
    strap_hold <= host_reset_i ? 4'hF : strap_hold - {3'h0, |strap_hold};
  end

  assign fundamental_reset_n_o  = ~host_reset_i;
  assign wake_request_n_o       = ~wake_i;
  assign slot_present_n_o       = ~insert_i;
  assign shared_refclk_select_o = refclk_sel_i;
  // Strap resistor removed shortly after reset; internal pull-down wins
  assign power_saving_strap_o   = (strap_hold != 4'h0) ? strap_i : 1'b0;
  assign gpio_wire_o            = (gpio_oe_i & gpio_drv_i) | (~gpio_oe_i & gpio_ext_i);
endmodule : host_slot_model

// ---- dv/tb_top.sv ----
// Self-checking bench for the switch sideband control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned HALF  = 8;
  localparam int unsigned LIMIT = 20000;

  logic       core_clk = 1'b0;
  logic       rst_n    = 1'b0;
  logic       host_rst = 1'b1;
  logic       wake     = 1'b0;
  logic [2:1] insert   = 2'h0;
  logic       refclk   = 1'b0;
  logic       strap    = 1'b1;
  logic [7:0] gpio_ext = 8'h00;
  logic [7:0] gpio_val = 8'h00;
  logic [7:0] gpio_en  = 8'h00;
  logic       smb      = 1'b0;
  logic [2:0] phy_err  = 3'h0;
  logic [2:0] phy_clr  = 3'h0;
  logic       tmode    = 1'b0;
  logic       scan_en  = 1'b0;
  logic       tck      = 1'b0;
  logic       tdi      = 1'b0;
  logic       tms      = 1'b0;
  logic       trst_n   = 1'b1;
  logic       fr_n, wake_n, ref_sel, strap_pin, beacon, ref_used, pse, se_o, se_oe, tdo;
  logic [2:1] pres_n, drst_n, occ;
  logic [2:0] ind, seen, smba;
  logic [7:0] gpio_wire, gpo, gpoe, gpin, lvl;
  logic [31:0] pat, got;
  int         seed     = 55;
  int         failures = 0;
  int         checked  = 0;
  int         cycles   = 0;

  host_slot_model model (.core_clk_i(core_clk), .host_reset_i(host_rst), .wake_i(wake), .insert_i(insert),
    .refclk_sel_i(refclk), .strap_i(strap), .gpio_ext_i(gpio_ext), .gpio_drv_i(gpo), .gpio_oe_i(gpoe),
    .fundamental_reset_n_o(fr_n), .wake_request_n_o(wake_n), .slot_present_n_o(pres_n),
    .shared_refclk_select_o(ref_sel), .power_saving_strap_o(strap_pin), .gpio_wire_o(gpio_wire));

  switch_sideband_control #(.BLINK_HALF_CYC(HALF)) dut (.core_clk_i(core_clk), .rst_n_i(rst_n),
    .fundamental_reset_n_i(fr_n), .wake_request_n_i(wake_n), .slot_present_n_i(pres_n),
    .shared_refclk_select_i(ref_sel), .downstream_port_reset_n_o(drst_n), .beacon_request_o(beacon),
    .slot_occupied_o(occ), .shared_refclk_used_o(ref_used), .phy_error_i(phy_err),
    .phy_error_seen_clear_i(phy_clr), .phy_error_indicator_o(ind), .phy_error_seen_o(seen),
    .gpio_i(gpio_wire), .gpio_out_value_i(gpio_val), .gpio_output_enable_i(gpio_en), .smbus_used_i(smb),
    .gpio_o(gpo), .gpio_oe_o(gpoe), .gpio_in_o(gpin), .smbus_address_low_o(smba),
    .power_saving_strap_i(strap_pin), .power_saving_enable_o(pse), .scan_test_mode_i(tmode),
    .scan_enable_i(scan_en), .scan_enable_o(se_o), .scan_enable_oe_o(se_oe), .tck_i(tck), .tms_i(tms),
    .tdi_i(tdi), .test_reset_n_i(trst_n), .tdo_o(tdo));

  always #4 core_clk = ~core_clk;

  task automatic check(input string what, input logic [31:0] seen_v, input logic [31:0] exp_v);
    checked++;
    if (seen_v !== exp_v) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp_v, seen_v);
    end
  endtask : check

  function automatic logic [7:0] pin_level(input logic [7:0] en, input logic [7:0] val, input logic [7:0] ext);
    return (en & val) | (~en & ext);
  endfunction : pin_level

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  task automatic test_done();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done

  // Measures one full low and high run of a blinking indicator
  task automatic blink_port(input int p);
    int n;
    int k;
    k = 0;
    phy_err <= 3'h1 << p;
    while (ind[p] !== 1'b1 && k < 100) begin cyc(1); k++; end
    while (ind[p] !== 1'b0 && k < 100) begin cyc(1); k++; end
    n = 0;
    while (ind[p] === 1'b0 && n < 100) begin cyc(1); n++; end
    check("blink low run", n, HALF);
    n = 0;
    while (ind[p] === 1'b1 && n < 100) begin cyc(1); n++; end
    check("blink high run", n, HALF);
    check("quiet indicators", ind & ~(3'h1 << p), 3'h0);
    check("error seen", seen[p], 1'b1);
    phy_err <= 3'h0;
    cyc(4);
    check("indicator off", ind, 3'h0);
  endtask : blink_port

  task automatic tck_pulse(input logic b);
    tdi <= b;
    cyc(4);
    tck <= 1'b1;
    cyc(5);
    tck <= 1'b0;
    cyc(1);
  endtask : tck_pulse

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      $display("MISMATCH timeout expected done seen hang");
      test_done();
    end
  end

  initial begin
    cyc(6);
    rst_n <= 1'b1;
    cyc(6);
    check("dsr in reset", drst_n, 2'h0);
    check("scan pin value", se_o, 1'b0);
    check("scan pin drive", se_oe, 1'b1);
    host_rst <= 1'b0;
    cyc(30);
    check("strap frozen", pse, 1'b1);
    check("strap pin now low", strap_pin, 1'b0);
    $display("test reset and strap done");
    wake <= 1'b1;
    cyc(5);
    check("beacon on", beacon, 1'b1);
    wake <= 1'b0;
    cyc(5);
    check("beacon off", beacon, 1'b0);
    for (int i = 0; i < 4; i++) begin
      refclk <= 1'($random(seed));
      cyc(5);
      check("refclk used", ref_used, refclk);
    end
    $display("test wake and refclk done");
    for (int p = 1; p <= 2; p++) begin
      insert[p] <= 1'b1;
      cyc(6);
      check("occupied", occ, insert);
      check("dsr insert", drst_n, p == 1 ? 2'h2 : 2'h1);
      cyc(130);
      check("dsr released", drst_n, 2'h3);
      insert[p] <= 1'b0;
      cyc(5);
      check("empty", occ, 2'h0);
    end
    $display("test insertion done");
    for (int p = 0; p < 3; p++) blink_port(p);
    phy_err <= 3'h1;
    phy_clr <= 3'h7;
    cyc(2);
    check("set wins over clear", seen, 3'h1);
    phy_err <= 3'h0;
    cyc(2);
    check("clear", seen, 3'h0);
    phy_clr <= 3'h0;
    $display("test error lamps done");
    for (int i = 0; i < 20; i++) begin
      gpio_val <= 8'($random(seed));
      gpio_en  <= (i == 0) ? 8'h00 : 8'($random(seed));
      gpio_ext <= 8'($random(seed));
      smb      <= (i < 2) ? i[0] : 1'($random(seed));
      cyc(6);
      lvl = pin_level(gpio_en, gpio_val, gpio_ext);
      check("gpio oe", gpoe, gpio_en);
      check("gpio drive", gpo & gpio_en, gpio_val & gpio_en);
      check("gpio in", gpin, lvl);
      check("smb addr", smba, smb ? lvl[7:5] : 3'h0);
    end
    $display("test gpio done");
    tmode   <= 1'b1;
    scan_en <= 1'b1;
    trst_n  <= 1'b0;
    cyc(6);
    check("scan pin input", se_oe, 1'b0);
    check("tdo in tap reset", tdo, 1'b0);
    trst_n <= 1'b1;
    cyc(4);
    tck_pulse(1'b0);
    tck_pulse(1'b0);
    pat = $random(seed);
    for (int i = 0; i < 32; i++) tck_pulse(pat[i]);
    for (int i = 0; i < 32; i++) begin
      tck_pulse(~pat[i]);
      got[i] = tdo;
    end
    check("chain in and out", got, pat);
    check("last out", tdo, pat[31]);
    tms <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      tck_pulse(pat[i]);
      got[i] = tdo;
    end
    check("instruction in and out", got[7:0], {pat[3:0], sideband_pkg::TAP_IR_RESET});
    tms <= 1'b0;
    trst_n <= 1'b0;
    cyc(6);
    check("tdo after test reset", tdo, 1'b0);
    $display("test tap done");
    phy_err <= 3'h1;
    wake    <= 1'b1;
    cyc(6);
    phy_err  <= 3'h0;
    host_rst <= 1'b1;
    cyc(6);
    check("beacon cleared", beacon, 1'b0);
    check("sticky kept", seen, 3'h1);
    check("dsr on host reset", drst_n, 2'h0);
    $display("test fundamental reset done");
    test_done();
  end
endmodule : tb_top
